// file: pkg/swu_cfg.svh
// Constants of the sleep and interrupt wake-up controller.
`ifndef SWU_CFG_SVH
`define SWU_CFG_SVH
// ****************************************
// Timing
// ****************************************
`define SWU_CLK_PERIOD_NS 10
`define SWU_TOSC_NS 10
`define SWU_OST_TOSC 1024
`define SWU_WDT_TIMEOUT_MS 16
`define SWU_WDT_PS_NOMINAL 4
// ****************************************
// Addresses, field widths and reset values
// ****************************************
`define SWU_PC_W 13
`define SWU_SEL_W 4
`define SWU_VECTOR_ADDR 13'h0004
`define SWU_PC_RST 13'h0000
`define SWU_TO_RST 1'h1
`define SWU_PD_RST 1'h1
`endif

// file: pkg/swu_pkg.sv
// Types of the sleep and interrupt wake-up controller.
`include "swu_cfg.svh"
package swu_pkg;
    typedef logic [`SWU_PC_W-1:0] swu_pc_t;
    typedef logic [`SWU_SEL_W-1:0] swu_sel_t;
    typedef enum logic [1:0] {
        SWU_RUN,
        SWU_SLEEP,
        SWU_OST,
        SWU_NEXT
    } swu_state_e;
endpackage

// file: hdl/swu_wdt.sv
// Watchdog counter with prescaler and postscaler.
`timescale 1ns/1ps
`default_nettype none
`include "swu_cfg.svh"
module swu_wdt #(
    parameter int TIMEOUT_CYC = 1_600_000,
    parameter int PS_NOMINAL = `SWU_WDT_PS_NOMINAL
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic resetn,
    // Control
    input wire logic clear,
    input wire logic hold,
    input wire logic enable,
    input wire swu_pkg::swu_sel_t ps_sel,
    input wire swu_pkg::swu_sel_t post_sel,
    // Event
    output logic timeout
);
    localparam int UNIT_CYC = TIMEOUT_CYC >> PS_NOMINAL;
    if (UNIT_CYC < 1) begin : g_chk
        $error("swu_wdt: timeout too short for the nominal prescale");
    end
    logic [31:0] unit_q, unit_d;
    logic [15:0] scale_q, scale_d, post_q, post_d;
    logic [15:0] scale_last, post_last;
    logic to_q, to_d;
    assign timeout = to_q;
    // ****************************************
    // Next state
    // ****************************************
    always_comb begin
        scale_last = 16'((17'h1 << ps_sel) - 17'h1);
        post_last = 16'((17'h1 << post_sel) - 17'h1);
        unit_d = unit_q;
        scale_d = scale_q;
        post_d = post_q;
        to_d = 1'h0;
        if (clear || hold || !enable) begin
            unit_d = 32'h0000_0000;
            scale_d = 16'h0000;
            post_d = 16'h0000;
        end else if (unit_q == 32'(UNIT_CYC - 1)) begin
            unit_d = 32'h0000_0000;
            if (scale_q == scale_last) begin
                scale_d = 16'h0000;
                if (post_q == post_last) begin
                    post_d = 16'h0000;
                    to_d = 1'h1;
                end else begin
                    post_d = post_q + 16'h0001;
                end
            end else begin
                scale_d = scale_q + 16'h0001;
            end
        end else begin
            unit_d = unit_q + 32'h0000_0001;
        end
    end
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            unit_q <= 32'h0000_0000;
            scale_q <= 16'h0000;
            post_q <= 16'h0000;
            to_q <= 1'h0;
        end else begin
            unit_q <= unit_d;
            scale_q <= scale_d;
            post_q <= post_d;
            to_q <= to_d;
        end
    end
endmodule
`default_nettype wire

// file: hdl/swu_core.sv
// Sleep entry, interrupt wake-up and start-up delay sequencing.
`timescale 1ns/1ps
`default_nettype none
`include "swu_cfg.svh"
// Operation
// RL1 - Wake-up logic acts when a source has both enable and flag set.
// RL2 - Pending interrupt before sleep makes sleep a no-op, flags and watchdog untouched.
// RL3 - Interrupt during or after sleep: sleep completes, then wake immediately.
// RL4 - Effective sleep clears watchdog and scalers, sets timeout flag, clears power-down.
// RL5 - Power-down flag stays set when sleep ran as a no-op; software reads it.
// RL6 - Software should issue the watchdog clear just before sleeping.
// RL7 - Crystal mode waits 1024 oscillator periods on wake; RC mode has none.
// RL8 - Global enable set: run next instruction, then vector to 0004h; else in line.
// RL9 - Prescale 0100 without postscaler gives about 16 ms watchdog timeout.
// RL10 - During sleep the next sequential address is prefetched for wake-up.
// RL11 - Program counter and state held while asleep; resume from held position.
module swu_core #(
    parameter int N_SRC = 8,
    parameter int WDT_TIMEOUT_CYC = `SWU_WDT_TIMEOUT_MS * 1_000_000 / `SWU_CLK_PERIOD_NS
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic resetn,
    // Instruction sequencing
    input wire logic sleep_exec,
    input wire logic wdt_clear_exec,
    input wire logic next_instr_done,
    input wire swu_pkg::swu_pc_t pc_in,
    // Interrupt sources
    input wire logic global_interrupt_enable,
    input wire logic [N_SRC-1:0] int_enable,
    input wire logic [N_SRC-1:0] int_flag,
    // Configuration
    input wire logic osc_crystal_mode,
    input wire logic wdt_enable,
    input wire swu_pkg::swu_sel_t wdt_prescale_sel,
    input wire swu_pkg::swu_sel_t wdt_postscale_sel,
    // Core control
    output logic core_halt,
    output logic sleep_as_nop,
    output logic resume_exec,
    output logic vector_req,
    output swu_pkg::swu_pc_t resume_pc,
    output swu_pkg::swu_pc_t vector_addr,
    output logic watchdog_reset_req,
    // Status
    output logic timeout_status_flag,
    output logic powerdown_status_flag
);
    localparam int OST_CYC = (`SWU_OST_TOSC * `SWU_TOSC_NS + `SWU_CLK_PERIOD_NS - 1)
        / `SWU_CLK_PERIOD_NS;
    if (N_SRC < 1 || OST_CYC < 1 || OST_CYC > 2048) begin : g_chk
        $error("swu_core: unsupported source count or start-up delay");
    end
    localparam logic [10:0] OST_LAST = 11'(OST_CYC - 1);

    swu_pkg::swu_state_e state_q, state_d;
    swu_pkg::swu_pc_t pc_q, pc_d, vec_q, vec_d;
    logic [10:0] ost_q, ost_d;
    logic to_q, to_d, pd_q, pd_d, gie_q, gie_d;
    logic nop_q, nop_d, res_q, res_d, vreq_q, vreq_d, wrst_q, wrst_d;
    logic pending, wdt_clr, wdt_to, wake;

    // ****************************************
    // Wake condition
    // ****************************************
    assign pending = |(int_enable & int_flag); // RL1
    assign wake = pending || wdt_to;

    // Sleep keeps the watchdog running so it can wake the core; the start-up count
    // uses its own counter, ost_q, and the watchdog is held in reset for that time.
    swu_wdt #(
        .TIMEOUT_CYC(WDT_TIMEOUT_CYC),
        .PS_NOMINAL(`SWU_WDT_PS_NOMINAL)
    ) u_wdt (
        .sys_clk(sys_clk),
        .resetn(resetn),
        .clear(wdt_clr),
        .hold(state_q == swu_pkg::SWU_OST),
        .enable(wdt_enable),
        .ps_sel(wdt_prescale_sel),
        .post_sel(wdt_postscale_sel),
        .timeout(wdt_to) // RL9
    );

    // ****************************************
    // Sequencer
    // ****************************************
    always_comb begin
        state_d = state_q;
        pc_d = pc_q;
        vec_d = vec_q;
        ost_d = ost_q;
        to_d = to_q;
        pd_d = pd_q;
        gie_d = gie_q;
        nop_d = 1'h0;
        res_d = 1'h0;
        vreq_d = 1'h0;
        wrst_d = 1'h0;
        wdt_clr = wdt_clear_exec;
        unique case (state_q)
            swu_pkg::SWU_RUN: begin
                if (wdt_to) begin
                    to_d = 1'h0;
                    wrst_d = 1'h1;
                end
                if (sleep_exec) begin
                    if (pending) begin
                        // A no-op sleep leaves the flags alone but must not mask a watchdog event.
                        nop_d = 1'h1; // RL2 RL5
                    end else begin
                        wdt_clr = 1'h1; // RL4
                        to_d = 1'h1; // RL4
                        pd_d = 1'h0; // RL4
                        wrst_d = 1'h0;
                        pc_d = pc_in + 13'h0001; // RL10
                        state_d = swu_pkg::SWU_SLEEP;
                    end
                end
            end
            swu_pkg::SWU_SLEEP: begin
                if (wake) begin // RL3
                    if (wdt_to) begin
                        to_d = 1'h0;
                    end
                    gie_d = global_interrupt_enable && pending;
                    if (osc_crystal_mode) begin
                        ost_d = 11'h000; // RL7
                        state_d = swu_pkg::SWU_OST;
                    end else begin
                        res_d = 1'h1; // RL7
                        state_d = (global_interrupt_enable && pending) ?
                            swu_pkg::SWU_NEXT : swu_pkg::SWU_RUN;
                    end
                end
            end
            swu_pkg::SWU_OST: begin
                ost_d = ost_q + 11'h001;
                if (ost_q == OST_LAST) begin
                    res_d = 1'h1; // RL7 RL11
                    state_d = gie_q ? swu_pkg::SWU_NEXT : swu_pkg::SWU_RUN;
                end
            end
            swu_pkg::SWU_NEXT: begin
                if (next_instr_done) begin
                    vreq_d = 1'h1; // RL8
                    vec_d = `SWU_VECTOR_ADDR; // RL8
                    gie_d = 1'h0;
                    state_d = swu_pkg::SWU_RUN;
                end
            end
        endcase
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            state_q <= swu_pkg::SWU_RUN;
            pc_q <= `SWU_PC_RST;
            vec_q <= `SWU_PC_RST;
            ost_q <= 11'h000;
            to_q <= `SWU_TO_RST;
            pd_q <= `SWU_PD_RST;
            gie_q <= 1'h0;
            nop_q <= 1'h0;
            res_q <= 1'h0;
            vreq_q <= 1'h0;
            wrst_q <= 1'h0;
        end else begin
            state_q <= state_d;
            pc_q <= pc_d;
            vec_q <= vec_d;
            ost_q <= ost_d;
            to_q <= to_d;
            pd_q <= pd_d;
            gie_q <= gie_d;
            nop_q <= nop_d;
            res_q <= res_d;
            vreq_q <= vreq_d;
            wrst_q <= wrst_d;
        end
    end

    // The core must not advance while asleep or while the oscillator settles.
    assign core_halt = (state_q == swu_pkg::SWU_SLEEP) || (state_q == swu_pkg::SWU_OST); // RL11
    assign sleep_as_nop = nop_q;
    assign resume_exec = res_q;
    assign vector_req = vreq_q;
    assign resume_pc = pc_q;
    assign vector_addr = vec_q;
    assign watchdog_reset_req = wrst_q;
    assign timeout_status_flag = to_q;
    assign powerdown_status_flag = pd_q;

    // ****************************************
    // Checks
    // ****************************************
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!resetn);

    sequence s_sleep_taken;
        state_q == swu_pkg::SWU_RUN && sleep_exec && !pending;
    endsequence
    sequence s_wake_xtal;
        state_q == swu_pkg::SWU_SLEEP && wake && osc_crystal_mode;
    endsequence

    a_nop_keeps_flags: assert property (state_q == swu_pkg::SWU_RUN && sleep_exec && pending |=> // RL2
        sleep_as_nop && powerdown_status_flag == $past(pd_q) && state_q == swu_pkg::SWU_RUN)
        else $error("sleep with pending interrupt changed state or flags");
    a_sleep_sets_flags: assert property (s_sleep_taken |=> // RL4
        timeout_status_flag && !powerdown_status_flag && state_q == swu_pkg::SWU_SLEEP)
        else $error("effective sleep did not update status flags");
    a_sleep_clears_wdt: assert property (s_sleep_taken |=> u_wdt.unit_q == 32'h0000_0000 && // RL4
        u_wdt.scale_q == 16'h0000 && u_wdt.post_q == 16'h0000)
        else $error("effective sleep did not clear the watchdog");
    a_prefetch_next_pc: assert property (s_sleep_taken |=> resume_pc == $past(pc_in) + 13'h0001) // RL10
        else $error("held address is not the next sequential one");
    a_wake_immediate: assert property (state_q == swu_pkg::SWU_SLEEP && pending |=> // RL3
        state_q != swu_pkg::SWU_SLEEP)
        else $error("pending interrupt did not wake the core");
    a_ost_entry: assert property (s_wake_xtal |=> state_q == swu_pkg::SWU_OST && ost_q == 11'h000) // RL7
        else $error("crystal wake did not start the start-up delay");
    a_ost_holds: assert property (state_q == swu_pkg::SWU_OST && ost_q != OST_LAST |=> // RL7
        !resume_exec && state_q == swu_pkg::SWU_OST && core_halt)
        else $error("start-up delay ended early");
    a_ost_done: assert property (state_q == swu_pkg::SWU_OST && ost_q == OST_LAST |=> resume_exec) // RL7
        else $error("start-up delay did not end on time");
    a_rc_no_delay: assert property (state_q == swu_pkg::SWU_SLEEP && wake && !osc_crystal_mode |=> // RL7
        resume_exec && !core_halt)
        else $error("RC mode wake was delayed");
    a_vector_after_next: assert property (state_q == swu_pkg::SWU_NEXT && next_instr_done |=> // RL8
        vector_req && vector_addr == `SWU_VECTOR_ADDR ##1 !vector_req)
        else $error("vector request missing after the next instruction");
    a_inline_no_vector: assert property (resume_exec && !gie_q && state_q == swu_pkg::SWU_RUN |-> // RL8
        !vector_req [*2])
        else $error("vector taken with global enable clear");
    a_pc_held_asleep: assert property (core_halt |=> $stable(resume_pc)) // RL11
        else $error("held address changed while asleep");
endmodule
`default_nettype wire

// file: tb/swu_core_tb.sv
// Self-checking bench of the sleep and interrupt wake-up controller.
`timescale 1ns/1ps
`default_nettype none
module swu_core_tb;
    // ****************************************
    // Stimulus and observation signals
    // ****************************************
    // A short watchdog base keeps the run small: one timeout unit is ten cycles.
    localparam int TCYC = 160;
    logic sys_clk, resetn, sleep_exec, wdt_clear_exec, next_instr_done;
    logic global_interrupt_enable, osc_crystal_mode, wdt_enable;
    swu_pkg::swu_pc_t pc_in, resume_pc, vector_addr, pc_exp;
    logic [7:0] int_enable, int_flag;
    swu_pkg::swu_sel_t wdt_prescale_sel, wdt_postscale_sel;
    logic core_halt, sleep_as_nop, resume_exec, vector_req, watchdog_reset_req;
    logic timeout_status_flag, powerdown_status_flag;
    int checked, fail_count, cycles, seed, n, src;
    int m_pd, m_nop, m_pc, m_asleep;
    swu_core #(.N_SRC(8), .WDT_TIMEOUT_CYC(TCYC)) i_swu_core (
        .sys_clk(sys_clk), .resetn(resetn), .sleep_exec(sleep_exec),
        .wdt_clear_exec(wdt_clear_exec), .next_instr_done(next_instr_done), .pc_in(pc_in),
        .global_interrupt_enable(global_interrupt_enable), .int_enable(int_enable),
        .int_flag(int_flag), .osc_crystal_mode(osc_crystal_mode), .wdt_enable(wdt_enable),
        .wdt_prescale_sel(wdt_prescale_sel), .wdt_postscale_sel(wdt_postscale_sel),
        .core_halt(core_halt), .sleep_as_nop(sleep_as_nop), .resume_exec(resume_exec),
        .vector_req(vector_req), .resume_pc(resume_pc), .vector_addr(vector_addr),
        .watchdog_reset_req(watchdog_reset_req), .timeout_status_flag(timeout_status_flag),
        .powerdown_status_flag(powerdown_status_flag)
    );
    // ****************************************
    // Clock, timeout and shared tasks
    // ****************************************
    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 20000) begin
            fail_count++;
            conclude();
        end
    end
    // Reference model of sleep entry; the announced resume only ends its asleep phase.
    always @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            m_pd = 1;
            m_nop = 0;
            m_pc = 0;
            m_asleep = 0;
        end else begin
            m_nop = 0;
            if (resume_exec === 1'b1) begin
                m_asleep = 0;
            end
            if (sleep_exec === 1'b1 && m_asleep == 0) begin
                if ((int_enable & int_flag) != 8'h00) begin
                    m_nop = 1;
                end else begin
                    m_pd = 0;
                    m_asleep = 1;
                    m_pc = (pc_in + 1) % 8192;
                end
            end
        end
    end
    always @(negedge sys_clk) begin
        if (resetn === 1'b1) begin
            check("model_nop", sleep_as_nop, 16'(m_nop));
            check("model_pd", powerdown_status_flag, 16'(m_pd));
            check("model_pc", resume_pc, 16'(m_pc));
        end
    end
    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp) begin
            fail_count++;
            $display("unexpected %s: expected %h, seen %h", name, exp, seen);
        end
    endtask
    task automatic conclude();
        $display("checked %0d, fail_count %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    task automatic do_sleep(input swu_pkg::swu_pc_t pc);
        @(negedge sys_clk);
        pc_in = pc;
        sleep_exec = 1'b1;
        @(negedge sys_clk);
        sleep_exec = 1'b0;
    endtask
    task automatic pulse_done();
        @(negedge sys_clk);
        next_instr_done = 1'b1;
        @(negedge sys_clk);
        next_instr_done = 1'b0;
    endtask
    // Counts falling edges until the core is told to resume, with a bound.
    task automatic wait_resume(output int cnt);
        cnt = 0;
        while (resume_exec !== 1'b1 && cnt < 3000) begin
            @(negedge sys_clk);
            cnt++;
        end
    endtask
    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        checked = 0;
        fail_count = 0;
        cycles = 0;
        seed = 32'he0e7;
        resetn = 1'b0;
        sleep_exec = 1'b0;
        wdt_clear_exec = 1'b0;
        next_instr_done = 1'b0;
        pc_in = 13'h0000;
        global_interrupt_enable = 1'b0;
        osc_crystal_mode = 1'b0;
        wdt_enable = 1'b0;
        wdt_prescale_sel = 4'h0;
        wdt_postscale_sel = 4'h0;
        int_enable = 8'h00;
        int_flag = 8'h00;
        repeat (5) @(negedge sys_clk);
        resetn = 1'b1;
        check("to_reset", timeout_status_flag, 16'h0001);
        check("pd_reset", powerdown_status_flag, 16'h0001);
        check("halt_reset", core_halt, 16'h0000);
        // A pending source turns back-to-back sleeps into no-ops.
        src = {$random(seed)} % 8;
        int_enable = 8'($random(seed));
        int_enable[src] = 1'b1;
        int_flag[src] = 1'b1;
        repeat (2) begin
            do_sleep(13'($random(seed)));
            check("nop", sleep_as_nop, 16'h0001);
            check("nop_halt", core_halt, 16'h0000);
            check("nop_pd", powerdown_status_flag, 16'h0001);
            check("nop_to", timeout_status_flag, 16'h0001);
        end
        // Every oscillator mode with either global enable setting.
        for (int mode = 0; mode < 4; mode++) begin
            @(negedge sys_clk);
            osc_crystal_mode = mode[0];
            global_interrupt_enable = mode[1];
            // Flags only where the enable is clear must not count as pending.
            int_flag = ~int_enable;
            pc_exp = 13'($random(seed));
            do_sleep(pc_exp);
            pc_exp = pc_exp + 13'h0001;
            check("sleep_halt", core_halt, 16'h0001);
            check("sleep_to", timeout_status_flag, 16'h0001);
            check("sleep_pd", powerdown_status_flag, 16'h0000);
            check("resume_pc", resume_pc, 16'(pc_exp));
            do_sleep(13'($random(seed)));
            check("halt_refuse", sleep_as_nop, 16'h0000);
            check("pc_held", resume_pc, 16'(pc_exp));
            int_flag[src] = 1'b1;
            wait_resume(n);
            check("wake_cycles", 16'(n), 16'(1 + 1024 * mode[0]));
            check("wake_halt", core_halt, 16'h0000);
            pulse_done();
            check("vector_req", vector_req, 16'(mode[1]));
            if (mode[1]) begin
                check("vector_addr", vector_addr, 16'h0004);
            end
            int_flag = 8'h00;
        end
        // Running watchdog with the nominal prescale and no postscaler.
        @(negedge sys_clk);
        global_interrupt_enable = 1'b1;
        wdt_enable = 1'b1;
        wdt_prescale_sel = 4'h4;
        wdt_clear_exec = 1'b1;
        @(negedge sys_clk);
        wdt_clear_exec = 1'b0;
        n = 0;
        while (watchdog_reset_req !== 1'b1 && n < 400) begin
            @(negedge sys_clk);
            n++;
        end
        check("wdt_period", 16'(n >= 158 && n <= 163), 16'h0001);
        check("wdt_to", timeout_status_flag, 16'h0000);
        // Watchdog wake from sleep: no vector even with the global enable set.
        @(negedge sys_clk);
        wdt_prescale_sel = 4'h0;
        osc_crystal_mode = 1'b0;
        wdt_clear_exec = 1'b1;
        @(negedge sys_clk);
        wdt_clear_exec = 1'b0;
        do_sleep(13'h1fff);
        check("wsleep_to", timeout_status_flag, 16'h0001);
        check("wsleep_pc", resume_pc, 16'h0000);
        wait_resume(n);
        wdt_enable = 1'b0;
        check("wwake", 16'(n < 40), 16'h0001);
        check("wwake_to", timeout_status_flag, 16'h0000);
        pulse_done();
        check("wwake_vec", vector_req, 16'h0000);
        conclude();
    end
endmodule
`default_nettype wire
